// ===== logic/diag_source_select.sv
// diagnostic source select register, slot latching and result registers
// What this block does
// - 16-bit read/write select register at 0x24, resets to 0x0000, four 4-bit fields.
// - Slot 3 selector in bits 15:12; undefined codes route analog ground.
// - Slot 2 selector in bits 11:8; undefined codes route analog ground.
// - Slot 1 selector in bits 7:4; undefined codes route analog ground.
// - Slot 0 selector in bits 3:0; undefined codes route analog ground.
// - Code 0000 selects analog ground, 0001 the temperature sensor.
// - Code 0010 selects analog supply, 0011 the negative pump supply.
// - Codes 0100-0111 select reference out, 5V, 1.8V analog, 1.8V digital regulators.
// - Code 1000 selects digital core supply, 1001 the interface supply.
// - Codes 1010-1101 select terminal sense pins A through D.
// - Code 1110 selects the low-voltage input; 1111 falls back to ground.
// - Each slot result sits read-only at 0x2A to 0x2D in slot order.
// - A slot converts only when its enable bit, conv control bits 7:4, is set.
module diag_source_select
	import diag_select_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// register port from the serial interface
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	output logic [DATA_W-1:0] REG_RDATA,
	output logic REG_HIT,
	// conversion control word, held by the register file
	input wire logic [DATA_W-1:0] CONV_CTRL,
	// sequencer side
	input wire logic [SLOTS-1:0] SLOT_CONV_START,
	input wire logic [SLOTS-1:0] SLOT_CONV_DONE,
	input wire logic [RES_W-1:0] CONV_RESULT,
	output logic [SLOTS-1:0] SLOT_CONV_ACTIVE,
	// analog mux controls, one-hot per slot
	output logic [NUM_SOURCES-1:0] SLOT_SOURCE [SLOTS]
);
	// register file side
	logic [DATA_W-1:0] select_r;
	logic [DATA_W-1:0] select_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic hit_r;
	logic hit_nxt;
	// address decode
	logic wr_select;
	logic rd_select;
	logic rd_result;
	logic rd_mapped;
	logic [1:0] result_idx;
	logic [DATA_W-1:0] read_word;
	// per-slot views: enables from the control word, busy and result gathered from the slot generate
	logic [SLOTS-1:0] slot_enable;
	wire logic [SLOTS-1:0] slot_busy;
	wire logic [RES_W-1:0] slot_result [SLOTS];

	// refuse geometries the packing and the read decode cannot serve
	generate
		if (SLOTS * SEL_W != DATA_W)
		begin : g_bad_pack
			$error("slot selector fields must exactly fill the select word");
		end
		if (SLOTS != 4)
		begin : g_bad_slots
			$error("result decode serves exactly four slots");
		end
		if (OFS_RESULT3 - OFS_RESULT0 + 1 != SLOTS)
		begin : g_bad_span
			$error("result offsets do not span one word per slot");
		end
		if (NUM_SOURCES > (1 << SEL_W))
		begin : g_bad_sources
			$error("selector code too narrow for the source count");
		end
		if (SLOT_EN_LSB + SLOTS > DATA_W)
		begin : g_bad_enable
			$error("slot enables fall outside the control word");
		end
		if (RES_W > DATA_W)
		begin : g_bad_result
			$error("result wider than the read port");
		end
	endgenerate

	// control word slot enables
	assign slot_enable = CONV_CTRL[SLOT_EN_LSB +: SLOTS];

	// address decode; only the select word takes writes, results are read-only
	assign wr_select = REG_WR && (REG_ADDR == OFS_SELECT);
	assign rd_select = REG_ADDR == OFS_SELECT;
	assign rd_result = (REG_ADDR >= OFS_RESULT0) && (REG_ADDR <= OFS_RESULT3);
	assign rd_mapped = rd_select || rd_result;
	assign result_idx = 2'(REG_ADDR - OFS_RESULT0);

	// next values
	assign select_nxt = wr_select ? REG_WDATA : select_r;
	assign read_word = rd_select ? select_r :
		rd_result ? slot_result[result_idx] : 16'h0000;
	// read data stands until the next read
	assign rdata_nxt = REG_RD ? read_word : rdata_r;
	assign hit_nxt = REG_RD && rd_mapped;

	// select register
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			select_r <= SELECT_RESET;
		end
		else
		begin
			select_r <= select_nxt;
		end
	end

	// read data
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			rdata_r <= 16'h0000;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	// mapped-read pulse
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			hit_r <= 1'b0;
		end
		else
		begin
			hit_r <= hit_nxt;
		end
	end

	genvar s;
	generate
		for (s = 0; s < SLOTS; s++)
		begin : g_slot
			logic [SEL_W-1:0] field;
			logic start_ok;
			logic done_ok;
			logic [NUM_SOURCES-1:0] onehot;
			logic [SEL_W-1:0] code_r;
			logic [SEL_W-1:0] code_nxt;
			logic busy_r;
			logic busy_nxt;
			logic [RES_W-1:0] res_r;
			logic [RES_W-1:0] res_nxt;
			logic [NUM_SOURCES-1:0] source_r;

			// field s occupies bits 4s+3:4s
			assign field = select_r[s*SEL_W +: SEL_W];
			// a start while busy or disabled is dropped
			assign start_ok = SLOT_CONV_START[s] && slot_enable[s] && !busy_r;
			// a stray done with no conversion running is dropped
			assign done_ok = SLOT_CONV_DONE[s] && busy_r;
			// code captured at start so a rewrite mid-conversion waits
			assign code_nxt = start_ok ? field : code_r;
			assign busy_nxt = start_ok ? 1'b1 : (done_ok ? 1'b0 : busy_r);
			assign res_nxt = done_ok ? CONV_RESULT : res_r;

			// held selector code
			always_ff @(posedge SYS_CLK)
			begin
				if (RST)
				begin
					code_r <= SRC_ANALOG_GROUND;
				end
				else
				begin
					code_r <= code_nxt;
				end
			end

			// conversion in progress
			always_ff @(posedge SYS_CLK)
			begin
				if (RST)
				begin
					busy_r <= 1'b0;
				end
				else
				begin
					busy_r <= busy_nxt;
				end
			end

			// result word
			always_ff @(posedge SYS_CLK)
			begin
				if (RST)
				begin
					res_r <= RESULT_RESET;
				end
				else
				begin
					res_r <= res_nxt;
				end
			end

			slot_source_decode u_decode (
				.code(code_r),
				.onehot(onehot)
			);

			// mux control, ground out of reset
			always_ff @(posedge SYS_CLK)
			begin
				if (RST)
				begin
					source_r <= NUM_SOURCES'(1);
				end
				else
				begin
					source_r <= onehot;
				end
			end

			assign slot_busy[s] = busy_r;
			assign slot_result[s] = res_r;
			assign SLOT_SOURCE[s] = source_r;
		end
	endgenerate

	assign SLOT_CONV_ACTIVE = slot_busy;
	assign REG_RDATA = rdata_r;
	assign REG_HIT = hit_r;
endmodule // diag_source_select

// ===== logic/diag_select_pkg.sv
// constants and types for the diagnostic source select block
package diag_select_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned SLOTS = 4;
	localparam int unsigned SEL_W = 4;
	localparam int unsigned RES_W = 16;
	localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_CONV_CTRL = 8'h23;
	localparam logic [ADDR_W-1:0] OFS_RESULT0 = 8'h2A;
	localparam logic [ADDR_W-1:0] OFS_RESULT3 = 8'h2D;
	localparam logic [DATA_W-1:0] SELECT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
	localparam int unsigned SLOT_EN_LSB = 4;
	localparam int unsigned SLOT3_LSB = 12;
	localparam int unsigned SLOT2_LSB = 8;
	localparam int unsigned SLOT1_LSB = 4;
	localparam int unsigned SLOT0_LSB = 0;

	// one-hot source index on the analog mux control bus
	typedef enum logic [SEL_W-1:0] {
		SRC_ANALOG_GROUND = 4'h0,
		SRC_TEMP_SENSOR = 4'h1,
		SRC_ANALOG_SUPPLY = 4'h2,
		SRC_NEG_PUMP_SUPPLY = 4'h3,
		SRC_REFERENCE_OUT = 4'h4,
		SRC_ANALOG_REG_5V = 4'h5,
		SRC_ANALOG_REG_1V8 = 4'h6,
		SRC_DIGITAL_REG_1V8 = 4'h7,
		SRC_DIGITAL_CORE = 4'h8,
		SRC_INTERFACE_SUPPLY = 4'h9,
		SRC_TERMINAL_A = 4'hA,
		SRC_TERMINAL_B = 4'hB,
		SRC_TERMINAL_C = 4'hC,
		SRC_TERMINAL_D = 4'hD,
		SRC_LOW_VOLTAGE_IN = 4'hE
	} source_type;
	localparam int unsigned NUM_SOURCES = 15;
endpackage

// ===== logic/slot_source_decode.sv
// decodes one slot selector into a one-hot source select
module slot_source_decode
	import diag_select_pkg::*;
(
	// selector code
	input wire logic [SEL_W-1:0] code,
	// one-hot source select
	output logic [NUM_SOURCES-1:0] onehot
);
	logic [SEL_W-1:0] legal_code;

	// 1111 falls back to ground
	assign legal_code = (code == 4'hF) ? SRC_ANALOG_GROUND : code;
	// codes 0..14 map straight onto source order
	assign onehot = NUM_SOURCES'(1) << legal_code;
endmodule // slot_source_decode

// ===== sim/diag_select_chk.sv
// assertions and covers on the select block ports
module diag_select_chk import diag_select_pkg::*; (
	// watched ports
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic [DATA_W-1:0] REG_RDATA,
	input wire logic REG_HIT,
	input wire logic [DATA_W-1:0] CONV_CTRL,
	input wire logic [SLOTS-1:0] SLOT_CONV_START,
	input wire logic [SLOTS-1:0] SLOT_CONV_DONE,
	input wire logic [SLOTS-1:0] SLOT_CONV_ACTIVE,
	input wire logic [NUM_SOURCES-1:0] SLOT_SOURCE [SLOTS]
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	wire logic mapped = REG_ADDR inside {OFS_SELECT, [OFS_RESULT0:OFS_RESULT3]};
	map_hit_a: assert property (REG_RD && mapped |=> REG_HIT)
		else $error("no hit");
	unmap_zero_a: assert property (REG_RD && !mapped |=> !REG_HIT && REG_RDATA == 16'h0000)
		else $error("unmapped read");
	wr_echo_a: assert property (REG_WR && REG_ADDR == OFS_SELECT ##2 REG_RD && !REG_WR
		&& !$past(REG_WR) && REG_ADDR == OFS_SELECT |=> REG_RDATA == $past(REG_WDATA, 3))
		else $error("select echo");
	start_act_a: assert property (SLOT_CONV_START[1] && CONV_CTRL[5] && !SLOT_CONV_ACTIVE[1]
		|=> SLOT_CONV_ACTIVE[1]) else $error("start");
	start_off_a: assert property (SLOT_CONV_START[2] && !CONV_CTRL[6] && !SLOT_CONV_ACTIVE[2]
		|=> !SLOT_CONV_ACTIVE[2]) else $error("refused");
	done_idle_a: assert property (SLOT_CONV_ACTIVE[3] && SLOT_CONV_DONE[3]
		|=> !SLOT_CONV_ACTIVE[3]) else $error("done");
	src_hold_a: assert property (SLOT_CONV_ACTIVE[0] && $past(SLOT_CONV_ACTIVE[0], 2)
		|-> $stable(SLOT_SOURCE[0])) else $error("hold");
	src_onehot_a: assert property ($onehot(SLOT_SOURCE[3])) else $error("onehot");
	cover property (REG_HIT);
	cover property (SLOT_CONV_DONE[0] && SLOT_CONV_ACTIVE[0]);
	cover property (SLOT_CONV_START[2] && !CONV_CTRL[6]);
endmodule // diag_select_chk
bind diag_source_select diag_select_chk u_chk (.*);

// ===== sim/diag_source_select_tb.sv
// self-checking bench for the select block
module diag_source_select_tb import diag_select_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic SYS_CLK = '0, RST = '1, REG_WR = '0, REG_RD = '0, REG_HIT, en;
	logic [ADDR_W-1:0] REG_ADDR = '0;
	logic [DATA_W-1:0] REG_WDATA = '0, CONV_CTRL = '0, REG_RDATA, v, w;
	logic [SLOTS-1:0] SLOT_CONV_START = '0, SLOT_CONV_DONE = '0, SLOT_CONV_ACTIVE;
	logic [RES_W-1:0] CONV_RESULT = '0;
	logic [NUM_SOURCES-1:0] SLOT_SOURCE [SLOTS], src_exp [SLOTS];
	logic [RES_W-1:0] res_exp [SLOTS];
	int fail_count = 0, samples_checked = 0, s;
	diag_source_select u_dut (.*);
	initial forever #10 SYS_CLK = ~SYS_CLK;
	task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (e !== g)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic print_verdict;
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(posedge SYS_CLK);
		{REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [15:0] e, logic h);
		@(posedge SYS_CLK);
		{REG_RD, REG_ADDR} <= {1'b1, a};
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		@(negedge SYS_CLK);
		cmp("rdata", e, REG_RDATA);
		cmp("hit", {15'h0000, h}, {15'h0000, REG_HIT});
	endtask
	task automatic chk_idle;
		@(negedge SYS_CLK);
		for (int k = 0; k < SLOTS; k++)
			cmp("source", 16'h0001, {1'b0, SLOT_SOURCE[k]});
		cmp("active", 16'h0000, {12'h000, SLOT_CONV_ACTIVE});
		rd(OFS_SELECT, SELECT_RESET, 1'b1);
	endtask
	initial
	begin
		void'($urandom(77));
		src_exp = '{default: 15'h0001};
		res_exp = '{default: 16'h0000};
		repeat (16) @(posedge SYS_CLK);
		RST <= 1'b0;
		chk_idle;
		rd(OFS_SELECT, SELECT_RESET, 1'b1);
		rd(8'h25, 16'h0000, 1'b0);
		for (int i = 0; i < 28; i++)
		begin
			s = i % 4;
			v = 16'($urandom());
			w = 16'($urandom());
			if (i < 16)
				v[s*4 +: 4] = i[3:0];
			en = i < 16 || i > 23;
			wr(OFS_SELECT, v);
			w[SLOT_EN_LSB + s] = en;
			CONV_CTRL <= w;
			@(posedge SYS_CLK);
			SLOT_CONV_START[s] <= 1'b1;
			@(posedge SYS_CLK);
			SLOT_CONV_START[s] <= 1'b0;
			w = 16'($urandom());
			wr(OFS_SELECT, w);
			rd(OFS_SELECT, w, 1'b1);
			if (en)
				src_exp[s] = v[s*4 +: 4] == 4'hF ? 15'h0001 : 15'h0001 << v[s*4 +: 4];
			cmp("source", {1'b0, src_exp[s]}, {1'b0, SLOT_SOURCE[s]});
			cmp("active", {15'h0000, en}, {15'h0000, SLOT_CONV_ACTIVE[s]});
			@(posedge SYS_CLK);
			SLOT_CONV_DONE[s] <= 1'b1;
			CONV_RESULT <= v;
			@(posedge SYS_CLK);
			SLOT_CONV_DONE[s] <= 1'b0;
			if (en)
				res_exp[s] = v;
			rd(OFS_RESULT0 + 8'(s), res_exp[s], 1'b1);
		end
		@(posedge SYS_CLK);
		RST <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		RST <= 1'b0;
		res_exp = '{default: RESULT_RESET};
		chk_idle;
		rd(OFS_RESULT0, RESULT_RESET, 1'b1);
		wr(OFS_RESULT3, 16'hFFFF);
		rd(OFS_RESULT3, res_exp[3], 1'b1);
		print_verdict;
	end
endmodule // diag_source_select_tb
